// file: common/nbp_pkg.sv
// nbp_pkg: command codes, status bits, query field layouts, register map
// and reset values for the buffered program command interpreter.
// assumes one 40 MHz aclk domain and an AXI4-Lite master with 32-bit data.
package nbp_pkg;

   // ----------------------------------------------------------------
   // bus widths and command codes
   // ----------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int AXI_DW = 32;
   localparam logic [7:0] CMD_BUF_SETUP = 8'hE8;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [15:0] COUNT_MAX = 16'h01FF;
   localparam int BUF_DEPTH = 512;

   // ----------------------------------------------------------------
   // status register of the flash side
   // ----------------------------------------------------------------
   localparam int SR_READY_BIT = 7;
   localparam logic [7:0] SR_SEQ_ERR = 8'h30;
   localparam logic [7:0] SR_RESET = 8'h80;

   // ----------------------------------------------------------------
   // query field layouts
   // ----------------------------------------------------------------
   localparam int RG_X_LSB = 0;
   localparam int RG_LEG_LO_BIT = 15;
   localparam int RG_VALID_LSB = 16;
   localparam int RG_INVAL_LSB = 32;
   localparam int RG_LEG_HI_BIT = 47;
   localparam logic [47:0] RG_WMASK = 48'h80FF_00FF_80FF;
   localparam int LK_OFS_LSB = 0;
   localparam int LK_SEG_LSB = 10;
   localparam int LK_TYPE_LSB = 28;
   localparam int LK_MORE_BIT = 31;
   localparam int QT_N_LSB = 0;
   localparam int QT_DIE_BIT = 4;
   localparam int QT_LOC_BIT = 5;
   localparam logic [7:0] QT_WMASK = 8'h3F;

   // ----------------------------------------------------------------
   // register map and interrupt bits
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_FSTAT = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_RGN_LO = 8'h10;
   localparam logic [7:0] REG_RGN_HI = 8'h14;
   localparam logic [7:0] REG_RGN_EFF = 8'h18;
   localparam logic [7:0] REG_LINK = 8'h1C;
   localparam logic [7:0] REG_QTY = 8'h20;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam int IRQ_ABORT = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_COUNT = 2;
   localparam int IRQ_W = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0]
   {
      FSM_IDLE,
      FSM_COUNT,
      FSM_DATA,
      FSM_CONFIRM,
      FSM_PROGRAM
   } nbp_fsm_e;

endpackage

// file: core/nbp_pin_sync.sv
// nbp_pin_sync: three-stage synchroniser with agreement filter for pins.
// assumes its inputs are asynchronous to aclk; output is aclk-domain.
module nbp_pin_sync
   #(parameter int W = 8,
     parameter logic [W-1:0] RST_VAL = '0)
   (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pins in, filtered levels out
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
   );

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } nbp_sync_s;

   nbp_sync_s s;
   nbp_sync_s next_s;

   // a bit moves only once stages two and three agree, so a level caught
   // mid-transition never reaches the command logic
   always_comb
   begin
      next_s = s;
      next_s.s1 = din;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.out = (s.out & (s.s2 ^ s.s3)) | (s.s3 & ~(s.s2 ^ s.s3));
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s.s1 <= RST_VAL;
         s.s2 <= RST_VAL;
         s.s3 <= RST_VAL;
         s.out <= RST_VAL;
      end
      else
         s <= next_s;
   end

   assign dout = s.out;

endmodule

// file: core/nbp_core.sv
// nbp_core: flash-side buffered program command interpreter with query
// field registers, reached by software over AXI4-Lite.
// assumes the host drives the flash pins asynchronously and an external
// array takes prog_* words and answers array_addr with array_rdata.
module nbp_core
   #(parameter int ADDR_W = 26,
     parameter int BLK_SHIFT = 16,
     parameter int AXI_AW = 8)
   (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // flash pins
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [nbp_pkg::DATA_W-1:0] data_lines_in,
   output logic [nbp_pkg::DATA_W-1:0] data_lines_out,
   output logic data_lines_oe,
   // array side
   input wire logic [nbp_pkg::DATA_W-1:0] array_rdata,
   output logic [ADDR_W-1:0] array_addr,
   output logic prog_valid,
   output logic [ADDR_W-1:0] prog_addr,
   output logic [nbp_pkg::DATA_W-1:0] prog_data,
   // axi4-lite write
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [nbp_pkg::AXI_DW-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [nbp_pkg::AXI_DW-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // interrupt
   output logic irq
   );
   import nbp_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      nbp_fsm_e fsm;
      logic rd_status;
      logic [7:0] sr;
      logic [8:0] count;
      logic [8:0] idx;
      logic [ADDR_W-1:0] start;
      logic prev_we_n;
      logic prev_rd;
      logic rd_seen;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
      logic [ADDR_W-1:0] arr_addr;
      logic prog_valid;
      logic [ADDR_W-1:0] prog_addr;
      logic [DATA_W-1:0] prog_data;
      logic ctrl_en;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
      logic [31:0] region_lo;
      logic [15:0] region_hi;
      logic [31:0] link;
      logic [7:0] qty;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_got;
      logic w_got;
      logic [AXI_AW-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } nbp_state_s;

   nbp_state_s s;
   nbp_state_s next_s;

   logic [DATA_W-1:0] buf_mem [0:BUF_DEPTH-1];
   logic [DATA_W-1:0] buf_rd;
   logic buf_we;
   logic ce_f;
   logic oe_f;
   logic we_f;
   logic [ADDR_W-1:0] addr_f;
   logic [DATA_W-1:0] dq_f;
   logic wr_ok;
   logic rd_act;
   logic rd_start;
   logic [7:0] cmd;
   logic [47:0] region;
   logic [31:0] rgn_eff;
   logic [31:0] qty_word;

   generate
      if (BLK_SHIFT < 10 || BLK_SHIFT >= ADDR_W || AXI_AW < 6)
         $error("nbp_core: unsupported ADDR_W, BLK_SHIFT or AXI_AW");
   endgenerate

   // ----------------------------------------------------------------
   // pin synchronisers and strobe detection
   // ----------------------------------------------------------------
   nbp_pin_sync #(
      .W(3 + ADDR_W + DATA_W),
      .RST_VAL({3'b111, {(ADDR_W + DATA_W){1'b0}}})
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({ce_n, oe_n, we_n, addr, data_lines_in}),
      .dout({ce_f, oe_f, we_f, addr_f, dq_f})
   );

   // a host write is taken on the rising edge of the write strobe
   assign wr_ok = s.ctrl_en && !ce_f && we_f && !s.prev_we_n;
   assign rd_act = !ce_f && !oe_f;
   // array_addr trails the pins by one cycle, so the read word is caught
   // one cycle into the read, once the array answers the new address
   assign rd_start = rd_act && s.prev_rd && !s.rd_seen;
   assign cmd = dq_f[7:0];
   assign buf_rd = buf_mem[s.idx];

   // reserved bits are never stored, legacy bits hide their sizes
   assign region = {s.region_hi, s.region_lo};
   assign rgn_eff = {6'h00, region[RG_LEG_HI_BIT],
      region[RG_LEG_LO_BIT],
      region[RG_LEG_HI_BIT] ? 8'h00 : region[RG_INVAL_LSB +: 8],
      region[RG_LEG_HI_BIT] ? 8'h00 : region[RG_VALID_LSB +: 8],
      region[RG_LEG_LO_BIT] ? 8'h00 : region[RG_X_LSB +: 8]};
   assign qty_word = {12'h000, s.link[LK_TYPE_LSB +: 3],
      s.link[LK_MORE_BIT], 3'h0,
      5'(s.qty[QT_N_LSB +: 4]) + 5'h01, s.qty};

   function automatic logic [31:0] reg_word(input logic [AXI_AW-1:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (8'(a))
         REG_CTRL: r = {31'h0000_0000, s.ctrl_en};
         REG_FSTAT: r = {11'h000, s.count, 3'(s.fsm), s.rd_status, s.sr};
         REG_IRQ_STAT: r = {29'h0000_0000, s.irq_stat};
         REG_IRQ_MASK: r = {29'h0000_0000, s.irq_mask};
         REG_RGN_LO: r = s.region_lo;
         REG_RGN_HI: r = {16'h0000, s.region_hi};
         REG_RGN_EFF: r = rgn_eff;
         REG_LINK: r = s.link;
         REG_QTY: r = qty_word;
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   function automatic logic mapped(input logic [AXI_AW-1:0] a);
      return (a[1:0] == 2'b00) && (8'(a) <= REG_QTY)
         && (a[AXI_AW-1:0] == AXI_AW'(8'(a)));
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[8*i +: 8] = nw[8*i +: 8];
      return r;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] clr;
      logic [31:0] wv;
      logic [47:0] rg;
      ev = '0;
      clr = '0;
      wv = 32'h0000_0000;
      rg = region;
      buf_we = 1'b0;
      next_s = s;
      next_s.prev_we_n = we_f;
      next_s.prev_rd = rd_act;
      next_s.rd_seen = rd_act && s.prev_rd;
      next_s.dq_oe = rd_act;
      next_s.arr_addr = addr_f;
      next_s.prog_valid = 1'b0;

      // status is latched once per read cycle, so the host must end the
      // cycle with select or output enable to see a fresh value
      if (rd_start)
         next_s.dq_out = s.rd_status ? {8'h00, s.sr} : array_rdata;

      if (wr_ok)
      begin
         case (s.fsm)
            FSM_IDLE:
            begin
               case (cmd)
                  CMD_BUF_SETUP:
                  begin
                     next_s.fsm = FSM_COUNT;
                     next_s.start = addr_f;
                     next_s.rd_status = 1'b1;
                  end
                  CMD_READ_STATUS: next_s.rd_status = 1'b1;
                  CMD_CLEAR_STATUS: next_s.sr = s.sr & ~SR_SEQ_ERR;
                  CMD_READ_ARRAY: next_s.rd_status = 1'b0;
                  default: next_s.fsm = FSM_IDLE;
               endcase
            end
            FSM_COUNT:
            begin
               // any word up to COUNT_MAX here, the status command included, is a count
               if (dq_f > COUNT_MAX)
               begin
                  next_s.fsm = FSM_IDLE;
                  next_s.sr = s.sr | SR_SEQ_ERR;
                  ev[IRQ_ABORT] = 1'b1;
               end
               else
               begin
                  next_s.count = dq_f[8:0];
                  next_s.idx = 9'h000;
                  next_s.fsm = FSM_DATA;
                  ev[IRQ_COUNT] = 1'b1;
               end
            end
            FSM_DATA:
            begin
               if (addr_f[ADDR_W-1:BLK_SHIFT] != s.start[ADDR_W-1:BLK_SHIFT])
               begin
                  next_s.fsm = FSM_IDLE;
                  next_s.sr = s.sr | SR_SEQ_ERR;
                  ev[IRQ_ABORT] = 1'b1;
               end
               else
               begin
                  buf_we = 1'b1;
                  if (s.idx == s.count)
                     next_s.fsm = FSM_CONFIRM;
                  else
                     next_s.idx = s.idx + 9'h001;
               end
            end
            FSM_CONFIRM:
            begin
               if (cmd == CMD_CONFIRM)
               begin
                  next_s.fsm = FSM_PROGRAM;
                  next_s.idx = 9'h000;
                  next_s.sr[SR_READY_BIT] = 1'b0;
               end
               else
               begin
                  next_s.fsm = FSM_IDLE;
                  next_s.sr = s.sr | SR_SEQ_ERR;
                  ev[IRQ_ABORT] = 1'b1;
               end
            end
            default: next_s.fsm = s.fsm;
         endcase
      end

      // one buffered word per cycle, walking up from the start address;
      // host writes are ignored until the array is written
      if (s.fsm == FSM_PROGRAM)
      begin
         next_s.prog_valid = 1'b1;
         next_s.prog_addr = s.start + ADDR_W'(s.idx);
         next_s.prog_data = buf_rd;
         if (s.idx == s.count)
         begin
            next_s.fsm = FSM_IDLE;
            next_s.sr[SR_READY_BIT] = 1'b1;
            ev[IRQ_DONE] = 1'b1;
         end
         else
            next_s.idx = s.idx + 9'h001;
      end

      // axi write: address and data in either order, answer after both
      if (awvalid && s.awready)
      begin
         next_s.aw_got = 1'b1;
         next_s.waddr = awaddr;
      end
      if (wvalid && s.wready)
      begin
         next_s.w_got = 1'b1;
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
      end
      if (s.bvalid && bready)
         next_s.bvalid = 1'b0;
      if (s.aw_got && s.w_got && !s.bvalid)
      begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = mapped(s.waddr) ? RESP_OKAY : RESP_SLVERR;
         wv = merge(reg_word(s.waddr), s.wdata, s.wstrb);
         if (mapped(s.waddr))
         begin
            case (8'(s.waddr))
               REG_CTRL: next_s.ctrl_en = wv[0];
               REG_IRQ_STAT: clr = s.wdata[IRQ_W-1:0] & {IRQ_W{s.wstrb[0]}};
               REG_IRQ_MASK: next_s.irq_mask = wv[IRQ_W-1:0];
               REG_RGN_LO: rg[31:0] = wv;
               REG_RGN_HI: rg[47:32] = wv[15:0];
               REG_LINK: next_s.link = wv;
               REG_QTY: next_s.qty = wv[7:0] & QT_WMASK;
               default: next_s.ctrl_en = s.ctrl_en;
            endcase
         end
      end
      rg = rg & RG_WMASK;
      next_s.region_lo = rg[31:0];
      next_s.region_hi = rg[47:32];

      // axi read: one answer per address, the cycle after it is taken
      if (s.rvalid && rready)
         next_s.rvalid = 1'b0;
      if (arvalid && s.arready)
      begin
         next_s.rvalid = 1'b1;
         next_s.rdata = reg_word(araddr);
         next_s.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end

      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;

      // an event in the same cycle as its clear stays set
      next_s.irq_stat = (s.irq_stat & ~clr) | ev;
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.sr <= SR_RESET;
         s.ctrl_en <= CTRL_EN_RESET;
         s.prev_we_n <= 1'b1;
      end
      else
         s <= next_s;
   end

   always_ff @(posedge aclk)
   begin
      if (buf_we)
         buf_mem[s.idx] <= dq_f;
   end

   assign data_lines_out = s.dq_out;
   assign data_lines_oe = s.dq_oe;
   assign array_addr = s.arr_addr;
   assign prog_valid = s.prog_valid;
   assign prog_addr = s.prog_addr;
   assign prog_data = s.prog_data;
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = s.rdata;
   assign irq = s.irq;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_setup_cmd;
      wr_ok && s.fsm == FSM_IDLE && cmd == CMD_BUF_SETUP;
   endsequence

   sequence seq_confirm_cmd;
      wr_ok && s.fsm == FSM_CONFIRM && cmd == CMD_CONFIRM;
   endsequence

   chk_setup_status: assert property (
      seq_setup_cmd |=> s.rd_status && s.fsm == FSM_COUNT
         ##1 s.rd_status)
      else $error("status output not selected after setup");

   chk_count_load: assert property (
      wr_ok && s.fsm == FSM_COUNT && dq_f <= COUNT_MAX
         |=> s.count == $past(dq_f[8:0]) && s.fsm == FSM_DATA)
      else $error("word count not latched");

   chk_status_count: assert property (
      wr_ok && s.fsm == FSM_COUNT && dq_f == 16'h0070
         |=> s.count == 9'h070 && s.fsm == FSM_DATA && s.rd_status)
      else $error("status command not taken as count");

   chk_block_abort: assert property (
      wr_ok && s.fsm == FSM_DATA
         && addr_f[ADDR_W-1:BLK_SHIFT] != s.start[ADDR_W-1:BLK_SHIFT]
         |=> s.fsm == FSM_IDLE && (s.sr & SR_SEQ_ERR) == SR_SEQ_ERR
         && s.irq_stat[IRQ_ABORT])
      else $error("out of block word did not abort");

   chk_prog_start: assert property (
      seq_confirm_cmd |=> s.fsm == FSM_PROGRAM && !s.sr[SR_READY_BIT]
         ##1 (s.prog_valid && s.prog_addr == s.start))
      else $error("programming did not begin at start address");

   chk_flag_sticky: assert property (
      s.sr[4] && !(wr_ok && s.fsm == FSM_IDLE
         && cmd == CMD_CLEAR_STATUS) |=> s.sr[4])
      else $error("improper sequence flag lost");

   chk_read_array: assert property (
      wr_ok && s.fsm == FSM_IDLE && cmd == CMD_READ_ARRAY
         |=> !s.rd_status [*2])
      else $error("read array command ignored");

   chk_status_hold: assert property (
      !rd_start |=> $stable(s.dq_out))
      else $error("read data changed within a read cycle");

   chk_region_legacy: assert property (
      region[RG_LEG_LO_BIT] |-> rgn_eff[7:0] == 8'h00)
      else $error("legacy exponent not hidden");

   chk_region_rsvd: assert property (
      ((region & ~RG_WMASK) == 48'h0000_0000_0000)
         && (!region[RG_LEG_HI_BIT] || rgn_eff[23:8] == 16'h0000))
      else $error("region reserved or legacy sizes visible");

   chk_qty_rsvd: assert property (
      s.qty[7:6] == 2'b00 && qty_word[12:8] == 5'(s.qty[3:0]) + 5'h01)
      else $error("link quantity field wrong");

endmodule

// file: bench/nbp_host.sv
// nbp_host: behavioural flash host driving select, strobes, address, data.
// assumes the device samples these pins through its own aclk filters.
module nbp_host
   (
   // clock
   input wire logic aclk,
   // flash pins
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [25:0] addr,
   output logic [15:0] dl_in,
   input wire logic [15:0] dl_out,
   input wire logic dl_oe
   );
   timeunit 1ns;
   timeprecision 1ps;
   logic drv;
   logic [15:0] hd;
   // a line that neither side drives shows the inverse of the last value, never a stale copy
   assign dl_in = drv ? hd : (dl_oe ? dl_out : ~hd);
   initial
   begin
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      addr = '0;
      hd = '0;
      drv = 1'b0;
   end
   // no erase or suspend is ever issued, so their spacing holds
   // address and data outlast the strobe rise so the pin filters settle
   task automatic wr(input logic [25:0] a, input logic [15:0] d);
      @(posedge aclk);
      addr <= a;
      hd <= d;
      drv <= 1'b1;
      ce_n <= 1'b0;
      repeat (4) @(posedge aclk);
      we_n <= 1'b0;
      repeat (5) @(posedge aclk);
      we_n <= 1'b1;
      repeat (8) @(posedge aclk);
      ce_n <= 1'b1;
      drv <= 1'b0;
      repeat (5) @(posedge aclk);
   endtask
   // select drops after every read so the next read sees fresh status
   task automatic rd(input logic [25:0] a, output logic [15:0] d);
      @(posedge aclk);
      addr <= a;
      ce_n <= 1'b0;
      oe_n <= 1'b0;
      repeat (10) @(posedge aclk);
      // an undriven bus reads back as the inverse, so a missing enable fails
      d = (dl_oe === 1'b1) ? dl_out : ~dl_out;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      repeat (6) @(posedge aclk);
   endtask
endmodule

// file: bench/nor_buffered_program_and_query_fields_test.sv
// testbench: flash host on the pins, axi4-lite master on the registers.
// assumes nbp_core with default parameters and a fixed array pattern.
module nor_buffered_program_and_query_fields_test;
   timeunit 1ns;
   timeprecision 1ps;
   import nbp_pkg::*;
   logic aclk, aresetn, ce_n, oe_n, we_n, awvalid, wvalid, bready, arvalid;
   logic rready, awready, wready, bvalid, arready, rvalid, irq, dl_oe, pv;
   logic [25:0] addr, array_addr, prog_addr;
   logic [15:0] dl_in, dl_out, prog_data, array_rdata, st;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rr;
   logic [25:0] pa[$];
   logic [15:0] pd[$];
   int bad_count, tests_run, cyc;
   // start on a buffer boundary, low address bits clear
   localparam logic [25:0] S = 26'h0020000;
   assign array_rdata = array_addr[15:0] ^ 16'hA5A5;
   nbp_core u_dut(.aclk(aclk), .aresetn(aresetn), .ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .addr(addr), .data_lines_in(dl_in),
      .data_lines_out(dl_out), .data_lines_oe(dl_oe),
      .array_rdata(array_rdata), .array_addr(array_addr), .prog_valid(pv),
      .prog_addr(prog_addr), .prog_data(prog_data), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .irq(irq));
   nbp_host u_host(.aclk(aclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .addr(addr), .dl_in(dl_in), .dl_out(dl_out), .dl_oe(dl_oe));
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc++;
      if (pv === 1'b1)
      begin
         pa.push_back(prog_addr);
         pd.push_back(prog_data);
      end
      if (cyc == 8000)
      begin
         bad_count++;
         summarize();
      end
   end
   // ----------------------------------------------------------------
   // bus tasks and checks
   // ----------------------------------------------------------------
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      bit ap, wp;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ap = 1'b1;
      wp = 1'b1;
      while (ap || wp)
      begin
         @(posedge aclk);
         if (ap && awready === 1'b1)
         begin
            awvalid <= 1'b0;
            ap = 1'b0;
         end
         if (wp && wready === 1'b1)
         begin
            wvalid <= 1'b0;
            wp = 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      rr = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      axr(REG_FSTAT);
      chk(32'(rd[7:0]), 32'h80);
      axr(8'h40);
      chk({rd[29:0], rr}, {30'h0, RESP_SLVERR});
      axw(8'h40, 32'h0000_0001);
      chk(32'(rr), 32'(RESP_SLVERR));
      axw(REG_RGN_LO, 32'hFFFF_FFFF);
      axw(REG_RGN_HI, 32'hFFFF_FFFF);
      axr(REG_RGN_LO);
      chk(rd, 32'h00FF_80FF);
      axr(REG_RGN_HI);
      chk(rd, 32'h0000_80FF);
      axr(REG_RGN_EFF);
      chk(rd, 32'h0300_0000);
      axw(REG_RGN_LO, 32'h0012_0034);
      axw(REG_RGN_HI, 32'h0000_0056);
      axr(REG_RGN_EFF);
      chk(rd, 32'h0056_1234);
      axw(REG_LINK, 32'hB123_4567);
      axr(REG_LINK);
      chk(rd, 32'hB123_4567);
      axw(REG_QTY, 32'h0000_00FF);
      axr(REG_QTY);
      chk(rd, 32'h0007_103F);
      axw(REG_IRQ_MASK, 32'h7);
      chk(32'(rr), 32'(RESP_OKAY));
      // with flash writes disabled the setup command is ignored
      axw(REG_CTRL, 32'h0);
      u_host.wr(S, 16'h00E8);
      axr(REG_FSTAT);
      chk(32'(rd[11:8]), 32'h0);
      axw(REG_CTRL, 32'h1);
      // a read-status code where the count belongs is taken as the count
      u_host.wr(S, 16'h00E8);
      u_host.rd(S, st);
      chk(32'(st), 32'h80);
      u_host.wr(S, 16'h0070);
      axr(REG_FSTAT);
      chk(32'(rd[20:9]), 32'h382);
      u_host.wr(S + 26'h0010000, 16'h1234);
      u_host.rd(S, st);
      chk(32'(st), 32'hB0);
      u_host.rd(S, st);
      chk(32'(st), 32'hB0);
      chk(32'(irq), 32'h1);
      axr(REG_IRQ_STAT);
      chk(rd, 32'h5);
      u_host.wr(S, 16'h0050);
      u_host.rd(S, st);
      chk(32'(st), 32'h80);
      u_host.wr(S, 16'h00E8);
      u_host.wr(S, 16'h0200);
      u_host.rd(S, st);
      chk(32'(st), 32'hB0);
      u_host.wr(S, 16'h0050);
      axw(REG_IRQ_STAT, 32'h7);
      chk(32'(irq), 32'h0);
      u_host.wr(S, 16'h00E8);
      u_host.wr(S, 16'h0001);
      u_host.wr(S, 16'hBEEF);
      u_host.wr(S + 26'h1, 16'hCAFE);
      u_host.wr(S, 16'h00D0);
      repeat (20) @(posedge aclk);
      chk(32'(pa.size()), 32'h2);
      chk({pa[0], pd[0]}, {S, 16'hBEEF});
      chk({pa[1], pd[1]}, {S + 26'h1, 16'hCAFE});
      u_host.rd(S, st);
      chk(32'(st), 32'h80);
      axr(REG_IRQ_STAT);
      chk(rd, 32'h6);
      u_host.wr(S, 16'h00FF);
      u_host.rd(S + 26'h3, st);
      chk(32'(st), 32'hA5A6);
      summarize();
   end
endmodule
